/* File: i2c_ris_pkg.sv */
package i2c_ris_pkg;
   // Buffer depth and byte-command width
   localparam int FIFO_DEPTH = 8;
   localparam int CMD_W = 9;
   // Register offsets, byte addresses
   localparam logic [7:0] OFF_RAW_STATUS = 8'h34;
   localparam logic [7:0] OFF_RX_THRESH = 8'h38;
   localparam logic [7:0] OFF_TX_THRESH = 8'h3c;
   localparam logic [7:0] OFF_CLR_ALL = 8'h40;
   localparam logic [7:0] OFF_CLR_RD_REQ = 8'h50;
   localparam logic [7:0] OFF_ACTIVITY_CLEAR_REGISTER = 8'h5c;
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_DATA_CMD = 8'h10;
   localparam logic [7:0] OFF_EN_STATUS = 8'h9c;
   // Reset values
   localparam logic [7:0] RX_THRESH_RST = 8'h02;
   localparam logic [7:0] TX_THRESH_RST = 8'h02;
   // Control register bit positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_TXE_CTRL_BIT = 1;

   // Raw status bits 8 down to 0, packed in register order
   typedef struct packed {
      logic activity;
      logic slv_tx_done;
      logic tx_abort;
      logic rd_req;
      logic tx_empty;
      logic tx_over;
      logic rx_full;
      logic rx_over;
      logic rx_under;
   } raw_status_t;

   // Events and levels from the protocol engine
   typedef struct packed {
      logic slv_nack;
      logic tx_abort;
      logic rd_req;
      logic rx_byte;
      logic shift_done;
      logic sm_active;
   } engine_evt_t;

   // Software control
   typedef struct packed {
      logic tx_empty_ctrl;
      logic enable;
   } ctrl_t;
endpackage

/* File: sync2.sv */
`timescale 1ns/10ps
// Two-stage synchroniser for levels from outside pclk
module sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q; // First stage, read only by q

   // Register both stages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

/* File: sat_threshold.sv */
`timescale 1ns/10ps
// Turns a stored threshold field into an entry count, capped at depth
module sat_threshold #(
   parameter int DEPTH = 8,
   parameter bit PLUS_ONE = 1'b0,
   parameter int LW = 4
) (
   // Field and resulting count
   input wire logic [7:0] field,
   output logic [LW-1:0] entries
);
   // Refuse depths that the count width cannot hold
   if (DEPTH < 1 || DEPTH > 255 || (1 << LW) <= DEPTH) begin : g_bad_depth
      $error("sat_threshold: unsupported depth or width");
   end

   logic [8:0] raw; // Field plus optional one

   // Add offset, then saturate
   always_comb begin
      raw = {1'b0, field} + (PLUS_ONE ? 9'h001 : 9'h000);
      if (raw > 9'(DEPTH)) begin
         entries = LW'(DEPTH);
      end else begin
         entries = LW'(raw);
      end
   end
endmodule

/* File: i2c_raw_status.sv */
`timescale 1ns/10ps
// Behaviour
// RQ1 - Activity bit sticky until disable or clear-read
// RQ2 - Slave-transmit done on master NACK
// RQ3 - Transmit abort flag on failed transmit
// RQ4 - Read request flag, hold SCL low
// RQ5 - Read-request clear read drops read request
// RQ6 - Software services read via data register
// RQ7 - Software delays before changing slave address
// RQ8 - Tx low when level at/below threshold
// RQ9 - Empty-control waits for shift completion
// RQ10 - Tx low clears above threshold
// RQ11 - Disable flushes tx, tx low tracks activity
// RQ12 - Tx overflow on write when full
// RQ13 - Overflow/underflow flags clear after idle disable
// RQ14 - Rx high at/above threshold, auto-clears
// RQ15 - Disable flushes rx, rx high clears
// RQ16 - Rx overflow on byte when full
// RQ17 - Rx underflow on read when empty
// RQ18 - Rx threshold is value plus one, saturated
// RQ19 - Tx threshold is direct count, saturated
// RQ20 - Status bits reset zero, read-only
module i2c_raw_status #(
   parameter int DEPTH = i2c_ris_pkg::FIFO_DEPTH,
   parameter int LW = $clog2(DEPTH + 1)
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Protocol engine, same clock
   input wire i2c_ris_pkg::engine_evt_t evt,
   input wire logic [LW-1:0] tx_level,
   input wire logic [LW-1:0] rx_level,
   input wire logic [7:0] rx_data,
   // Buffer control towards the engine
   output logic tx_push,
   output logic [i2c_ris_pkg::CMD_W-1:0] tx_wdata,
   output logic rx_pop,
   output logic fifo_flush,
   output logic enable_status_bit,
   // Bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe
);
   // Refuse depths that the level width cannot count
   if (DEPTH < 1 || DEPTH > 255 || (1 << LW) <= DEPTH) begin : g_bad_depth
      $error("i2c_raw_status: unsupported depth");
   end

   // Register state
   i2c_ris_pkg::raw_status_t ris_q, ris_d; // Raw status flags
   i2c_ris_pkg::ctrl_t ctrl_q, ctrl_d; // Enable and empty control
   logic [7:0] rx_tl_q, rx_tl_d; // Stored receive threshold
   logic [7:0] tx_tl_q, tx_tl_d; // Stored transmit threshold
   logic en_stat_q, en_stat_d; // Enable status
   // Bus answer state
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   // Engine-facing outputs
   logic tx_push_q, tx_push_d;
   logic [i2c_ris_pkg::CMD_W-1:0] tx_wdata_q, tx_wdata_d;
   logic rx_pop_q, rx_pop_d;
   logic flush_q, flush_d;
   logic hold_q, hold_d; // SCL stretch request
   // Pin activity
   logic [1:0] pins_s; // Synchronised scl, sda, inverted so idle matches reset
   logic [1:0] pins_prev_q; // Previous synchronised sample
   logic bus_act; // Any edge seen on the pins
   // Effective thresholds in entries
   logic [LW-1:0] rx_thr;
   logic [LW-1:0] tx_thr;
   // Completed bus accesses
   logic done;
   logic wr_data, rd_data, rd_clr_all, rd_clr_rd, rd_clr_act;
   logic addr_ok; // Address decodes to a register

   // Pins come from another domain
   sync2 #(
      .W(2)
   ) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(~{scl_i, sda_i}),
      .q(pins_s)
   );

   // Receive threshold counts value plus one
   sat_threshold #(
      .DEPTH(DEPTH),
      .PLUS_ONE(1'b1),
      .LW(LW)
   ) u_rx_thr (
      .field(rx_tl_q),
      .entries(rx_thr) // RQ18
   );

   // Transmit threshold counts directly
   sat_threshold #(
      .DEPTH(DEPTH),
      .PLUS_ONE(1'b0),
      .LW(LW)
   ) u_tx_thr (
      .field(tx_tl_q),
      .entries(tx_thr) // RQ19
   );

   // Edge on either line marks bus activity
   assign bus_act = |(pins_s ^ pins_prev_q);

   // Access completes at the edge where pready is seen
   assign done = psel && penable && pready_q;
   assign wr_data = done && pwrite && paddr == i2c_ris_pkg::OFF_DATA_CMD;
   assign rd_data = done && !pwrite && paddr == i2c_ris_pkg::OFF_DATA_CMD;
   assign rd_clr_all = done && !pwrite && paddr == i2c_ris_pkg::OFF_CLR_ALL;
   assign rd_clr_rd = done && !pwrite && paddr == i2c_ris_pkg::OFF_CLR_RD_REQ;
   assign rd_clr_act = done && !pwrite && paddr == i2c_ris_pkg::OFF_ACTIVITY_CLEAR_REGISTER;

   // Address decode for the error answer
   always_comb begin
      unique case (paddr)
         i2c_ris_pkg::OFF_RAW_STATUS, i2c_ris_pkg::OFF_RX_THRESH,
         i2c_ris_pkg::OFF_TX_THRESH, i2c_ris_pkg::OFF_CLR_ALL,
         i2c_ris_pkg::OFF_CLR_RD_REQ, i2c_ris_pkg::OFF_ACTIVITY_CLEAR_REGISTER,
         i2c_ris_pkg::OFF_CONTROL, i2c_ris_pkg::OFF_DATA_CMD,
         i2c_ris_pkg::OFF_EN_STATUS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Bus answer: no wait state, read data captured at setup
   always_comb begin
      pready_d = 1'b0;
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
      if (psel && !penable) begin
         pready_d = 1'b1;
         pslverr_d = !addr_ok;
         if (!pwrite) begin
            unique case (paddr)
               i2c_ris_pkg::OFF_RAW_STATUS: prdata_d = {23'h0, ris_q};
               i2c_ris_pkg::OFF_RX_THRESH: prdata_d = {24'h0, rx_tl_q};
               i2c_ris_pkg::OFF_TX_THRESH: prdata_d = {24'h0, tx_tl_q};
               i2c_ris_pkg::OFF_CONTROL: prdata_d = {30'h0, ctrl_q};
               i2c_ris_pkg::OFF_EN_STATUS: prdata_d = {31'h0, en_stat_q};
               i2c_ris_pkg::OFF_DATA_CMD: prdata_d = {24'h0, rx_data};
               default: prdata_d = 32'h0000_0000;
            endcase
         end
      end
   end

   // Writable settings; thresholds saturate at depth
   always_comb begin
      ctrl_d = ctrl_q;
      rx_tl_d = rx_tl_q;
      tx_tl_d = tx_tl_q;
      if (done && pwrite) begin
         unique case (paddr)
            i2c_ris_pkg::OFF_CONTROL: begin
               ctrl_d.enable = pwdata[i2c_ris_pkg::CTRL_ENABLE_BIT];
               ctrl_d.tx_empty_ctrl = pwdata[i2c_ris_pkg::CTRL_TXE_CTRL_BIT];
            end
            i2c_ris_pkg::OFF_RX_THRESH: begin
               rx_tl_d = (pwdata[7:0] > 8'(DEPTH)) ? 8'(DEPTH) : pwdata[7:0]; // RQ18
            end
            i2c_ris_pkg::OFF_TX_THRESH: begin
               tx_tl_d = (pwdata[7:0] > 8'(DEPTH)) ? 8'(DEPTH) : pwdata[7:0]; // RQ19
            end
            default: begin
               // Writes to status and others leave settings
            end
         endcase
      end
   end

   // Engine-facing strobes and enable status
   always_comb begin
      en_stat_d = ctrl_q.enable || (en_stat_q && evt.sm_active);
      flush_d = !ctrl_q.enable; // RQ11 RQ15
      tx_push_d = wr_data && ctrl_q.enable && tx_level < LW'(DEPTH);
      tx_wdata_d = wr_data ? pwdata[i2c_ris_pkg::CMD_W-1:0] : tx_wdata_q;
      rx_pop_d = rd_data && ctrl_q.enable && rx_level != '0;
      // Stretch SCL until the request is answered with data
      if (evt.rd_req && ctrl_q.enable) begin
         hold_d = 1'b1; // RQ4
      end else if (wr_data || !ctrl_q.enable) begin
         hold_d = 1'b0; // RQ6
      end else begin
         hold_d = hold_q;
      end
   end

   // Raw status flags; a new event beats a clear in the same cycle
   always_comb begin
      ris_d = ris_q;
      // Disabling forces the activity bit low
      if (!ctrl_q.enable) begin
         ris_d.activity = 1'b0; // RQ1
      end else if (bus_act || evt.sm_active) begin
         ris_d.activity = 1'b1; // RQ1
      end else if (rd_clr_act || rd_clr_all) begin
         ris_d.activity = 1'b0; // RQ1
      end
      // Master NACK while slave-transmitting
      if (evt.slv_nack) begin
         ris_d.slv_tx_done = 1'b1; // RQ2
      end else if (rd_clr_all || !en_stat_q) begin
         ris_d.slv_tx_done = 1'b0;
      end
      // Abort reported by the engine
      if (evt.tx_abort) begin
         ris_d.tx_abort = 1'b1; // RQ3
      end else if (rd_clr_all || !en_stat_q) begin
         ris_d.tx_abort = 1'b0;
      end
      // Remote master read
      if (evt.rd_req && ctrl_q.enable) begin
         ris_d.rd_req = 1'b1; // RQ4
      end else if (rd_clr_rd || rd_clr_all || !en_stat_q) begin
         ris_d.rd_req = 1'b0; // RQ5
      end
      // Transmit level low follows level, or activity when disabled
      if (ctrl_q.enable) begin
         ris_d.tx_empty = tx_level <= tx_thr // RQ8 RQ10
            && (!ctrl_q.tx_empty_ctrl || evt.shift_done); // RQ9
      end else begin
         ris_d.tx_empty = en_stat_q; // RQ11
      end
      // Command written into a full transmit buffer
      if (wr_data && tx_level >= LW'(DEPTH)) begin
         ris_d.tx_over = 1'b1; // RQ12
      end else if (rd_clr_all || !en_stat_q) begin
         ris_d.tx_over = 1'b0; // RQ13
      end
      // Receive level high, flushed buffer reads empty
      ris_d.rx_full = ctrl_q.enable && rx_level >= rx_thr; // RQ14 RQ15
      // Byte arriving at a full receive buffer
      if (evt.rx_byte && ctrl_q.enable && rx_level >= LW'(DEPTH)) begin
         ris_d.rx_over = 1'b1; // RQ16
      end else if (rd_clr_all || !en_stat_q) begin
         ris_d.rx_over = 1'b0; // RQ13
      end
      // Data read from an empty receive buffer
      if (rd_data && (rx_level == '0 || !ctrl_q.enable)) begin
         ris_d.rx_under = 1'b1; // RQ17
      end else if (rd_clr_all || !en_stat_q) begin
         ris_d.rx_under = 1'b0; // RQ13
      end
   end

   // Register everything; status resets to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ris_q <= '0; // RQ20
         ctrl_q <= '0;
         rx_tl_q <= i2c_ris_pkg::RX_THRESH_RST;
         tx_tl_q <= i2c_ris_pkg::TX_THRESH_RST;
         en_stat_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         tx_push_q <= 1'b0;
         tx_wdata_q <= '0;
         rx_pop_q <= 1'b0;
         flush_q <= 1'b1;
         hold_q <= 1'b0;
         pins_prev_q <= 2'h0;
      end else begin
         ris_q <= ris_d;
         ctrl_q <= ctrl_d;
         rx_tl_q <= rx_tl_d;
         tx_tl_q <= tx_tl_d;
         en_stat_q <= en_stat_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         tx_push_q <= tx_push_d;
         tx_wdata_q <= tx_wdata_d;
         rx_pop_q <= rx_pop_d;
         flush_q <= flush_d;
         hold_q <= hold_d;
         pins_prev_q <= pins_s;
      end
   end

   // Outputs straight from flops, except scl_o which is tied low
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign tx_push = tx_push_q;
   assign tx_wdata = tx_wdata_q;
   assign rx_pop = rx_pop_q;
   assign fifo_flush = flush_q;
   assign enable_status_bit = en_stat_q;
   assign scl_o = 1'b0; // Open drain: only ever pulls low
   assign scl_oe = hold_q;

   // Checks, all on pclk
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_activity_disable: assert property ( // RQ1
      !ctrl_q.enable |=> !ris_q.activity)
      else $error("activity set while disabled");
   a_activity_sticky: assert property ( // RQ1
      ris_q.activity && ctrl_q.enable && !rd_clr_act && !rd_clr_all |=> ris_q.activity)
      else $error("activity dropped without clear");
   a_slave_done_set: assert property ( // RQ2
      evt.slv_nack |=> ris_q.slv_tx_done)
      else $error("slave transmit done missed");
   a_abort_flag_set: assert property ( // RQ3
      evt.tx_abort |=> ris_q.tx_abort)
      else $error("transmit abort missed");
   a_scl_hold_req: assert property ( // RQ4
      evt.rd_req && ctrl_q.enable |=> ris_q.rd_req && scl_oe ##1 (scl_oe || $past(wr_data)))
      else $error("read request without scl hold");
   a_rd_req_clear: assert property ( // RQ5
      rd_clr_rd && !evt.rd_req |=> !ris_q.rd_req)
      else $error("read request not cleared");
   a_tx_low_level: assert property ( // RQ8
      ctrl_q.enable && !ctrl_q.tx_empty_ctrl && tx_level <= tx_thr |=> ris_q.tx_empty)
      else $error("transmit low not set");
   a_tx_low_shift: assert property ( // RQ9
      ctrl_q.enable && ctrl_q.tx_empty_ctrl && !evt.shift_done |=> !ris_q.tx_empty)
      else $error("transmit low before shift done");
   a_tx_low_above: assert property ( // RQ10
      ctrl_q.enable && tx_level > tx_thr |=> !ris_q.tx_empty)
      else $error("transmit low above threshold");
   a_tx_flush_disable: assert property ( // RQ11
      !ctrl_q.enable |=> fifo_flush && ris_q.tx_empty == $past(en_stat_q))
      else $error("disable flush or transmit low wrong");
   a_tx_over_set: assert property ( // RQ12
      wr_data && tx_level >= LW'(DEPTH) |=> ris_q.tx_over && !tx_push)
      else $error("transmit overflow missed");
   a_over_idle_clear: assert property ( // RQ13
      !en_stat_q && !wr_data && !rd_data && !evt.rx_byte |=> !ris_q.tx_over && !ris_q.rx_over && !ris_q.rx_under)
      else $error("overflow flags not cleared at idle");
   a_rx_high_level: assert property ( // RQ14
      ctrl_q.enable |=> ris_q.rx_full == ($past(rx_level) >= $past(rx_thr)))
      else $error("receive high wrong");
   a_rx_high_disable: assert property ( // RQ15
      !ctrl_q.enable |=> !ris_q.rx_full)
      else $error("receive high while disabled");
   a_rx_over_set: assert property ( // RQ16
      evt.rx_byte && ctrl_q.enable && rx_level >= LW'(DEPTH) |=> ris_q.rx_over)
      else $error("receive overflow missed");
   a_rx_under_set: assert property ( // RQ17
      rd_data && rx_level == '0 |=> ris_q.rx_under && !rx_pop)
      else $error("receive underflow missed");
   a_thresh_range: assert property ( // RQ18
      rx_thr >= LW'(1) && rx_thr <= LW'(DEPTH) && tx_thr <= LW'(DEPTH)) // RQ19
      else $error("threshold out of range");
endmodule

/* File: i2c_bus_partner.sv */
`timescale 1ns/10ps
// Remote bus party: drives SCL and SDA, both lines pulled up
module i2c_bus_partner (
   // Block side of the SCL pin
   input wire logic scl_o,
   input wire logic scl_oe,
   // Line levels seen by the block
   output logic scl_i,
   output logic sda_i
);
   logic scl_drv; // Remote clock, still outside frames
   logic sda_drv; // Remote data, released high when idle
   // Wired-and: the block holds SCL low while it stretches
   assign scl_i = scl_drv & ~(scl_oe & ~scl_o);
   assign sda_i = sda_drv;
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   // Start, eight bits at 80 ns each, stop
   task automatic frame(input logic [7:0] b);
      #1; // Keeps line edges off the pclk sampling edge
      sda_drv = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #40 scl_drv = 1'b0;
         sda_drv = b[i];
         #40 scl_drv = 1'b1;
         // Waits out a stretch before the next bit
         wait (scl_i === 1'b1);
      end
      #40 scl_drv = 1'b0;
      sda_drv = 1'b0;
      #40 scl_drv = 1'b1;
      #40 sda_drv = 1'b1;
   endtask
endmodule

/* File: tb_i2c_raw_interrupt_status_low.sv */
`timescale 1ns/10ps
// Self-checking bench for the raw status block
module tb_i2c_raw_interrupt_status_low;
   // Short names for the busiest offsets
   localparam logic [7:0] ST = i2c_ris_pkg::OFF_RAW_STATUS;
   localparam logic [7:0] CTL = i2c_ris_pkg::OFF_CONTROL;
   localparam logic [7:0] DC = i2c_ris_pkg::OFF_DATA_CMD;
   localparam logic [7:0] RXT = i2c_ris_pkg::OFF_RX_THRESH;
   localparam logic [7:0] TXT = i2c_ris_pkg::OFF_TX_THRESH;
   // Clock, reset and bus signals
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, rx_data;
   logic [31:0] pwdata, prdata, rd;
   // Engine side
   i2c_ris_pkg::engine_evt_t evt;
   logic [3:0] tx_level, rx_level;
   logic [i2c_ris_pkg::CMD_W-1:0] tx_wdata;
   logic tx_push, rx_pop, fifo_flush, en_stat, scl_i, sda_i, scl_o, scl_oe;
   int error_cnt, n_tests;
   // Block under test
   i2c_raw_status dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .evt(evt), .tx_level(tx_level), .rx_level(rx_level), .rx_data(rx_data),
      .tx_push(tx_push), .tx_wdata(tx_wdata), .rx_pop(rx_pop), .fifo_flush(fifo_flush),
      .enable_status_bit(en_stat), .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe(scl_oe)
   );
   // Remote bus party
   i2c_bus_partner bus (.scl_o(scl_o), .scl_oe(scl_oe), .scl_i(scl_i), .sda_i(sda_i));
   // Bus clock, 4 ns period
   always #2 pclk = ~pclk;
   // Cuts a hang short
   initial begin
      #40000;
      $display("Error at %0t: watchdog expired", $time);
      error_cnt++;
      give_verdict();
   end
   // Prints the counts and the verdict, then stops
   task automatic give_verdict();
      $display("Mismatches %0d, checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Compares one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; read data and response land in rd and err
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         $display("Error at %0t: no pready", $time);
         error_cnt++;
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Reads the status word and compares the bits under the mask
   task automatic rd_st(input logic [8:0] e, input logic [8:0] m);
      repeat (2) @(posedge pclk);
      apb(ST, 1'b0, 32'h0);
      chk(rd & {23'h7fffff, m}, {23'h0, e & m});
   endtask
   // One-cycle event pulse
   task automatic pulse(input logic [5:0] p);
      @(posedge pclk);
      evt <= evt | p;
      @(posedge pclk);
      evt <= evt & ~p;
   endtask
   // New buffer levels
   task automatic lv(input logic [3:0] t, input logic [3:0] r);
      @(posedge pclk);
      tx_level <= t;
      rx_level <= r;
   endtask
   // Reset state, read-only status, unmapped place, enable
   task automatic t_reset();
      chk({31'h0, fifo_flush}, 32'h1);
      rd_st(9'h000, 9'h1ff);
      apb(ST, 1'b1, 32'h1ff);
      rd_st(9'h000, 9'h1ff);
      apb(RXT, 1'b0, 32'h0);
      chk(rd, 32'h2);
      apb(8'h24, 1'b0, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      apb(CTL, 1'b1, 32'h1);
      apb(i2c_ris_pkg::OFF_EN_STATUS, 1'b0, 32'h0);
      chk({fifo_flush, rd[30:0]}, 32'h1);
   endtask
   // Read request stretches SCL until the data write
   task automatic t_rdreq();
      pulse(6'h08);
      rd_st(9'h020, 9'h0ff);
      chk({31'h0, scl_oe}, 32'h1);
      chk({31'h0, scl_i}, 32'h0);
      apb(i2c_ris_pkg::OFF_CLR_RD_REQ, 1'b0, 32'h0);
      rd_st(9'h000, 9'h0ff);
      apb(DC, 1'b1, 32'h0a5);
      @(negedge pclk);
      chk({22'h0, tx_push, tx_wdata}, 32'h2a5);
      repeat (8) @(posedge pclk);
      chk({31'h0, scl_oe}, 32'h0);
      chk({31'h0, scl_i}, 32'h1);
      apb(i2c_ris_pkg::OFF_ACTIVITY_CLEAR_REGISTER, 1'b0, 32'h0);
   endtask
   // Activity is sticky and cleared by either clearing read
   task automatic t_activity();
      rd_st(9'h000, 9'h1ff);
      bus.frame(8'h5a);
      rd_st(9'h100, 9'h1ff);
      repeat (50) @(posedge pclk);
      rd_st(9'h100, 9'h1ff);
      apb(i2c_ris_pkg::OFF_ACTIVITY_CLEAR_REGISTER, 1'b0, 32'h0);
      rd_st(9'h000, 9'h1ff);
      bus.frame(8'h81);
      repeat (4) @(posedge pclk);
      apb(i2c_ris_pkg::OFF_CLR_ALL, 1'b0, 32'h0);
      rd_st(9'h000, 9'h1ff);
   endtask
   // Slave-transmit done and abort, a write that must not touch them
   task automatic t_events();
      pulse(6'h30);
      apb(ST, 1'b1, 32'h0);
      rd_st(9'h0c0, 9'h1ff);
      apb(i2c_ris_pkg::OFF_CLR_ALL, 1'b0, 32'h0);
      rd_st(9'h000, 9'h1ff);
   endtask
   // Transmit level low against threshold and shift completion
   task automatic t_tx();
      lv(4'h2, 4'h0);
      rd_st(9'h010, 9'h1ff);
      lv(4'h3, 4'h0);
      rd_st(9'h000, 9'h1ff);
      apb(TXT, 1'b1, 32'hff);
      apb(TXT, 1'b0, 32'h0);
      chk(rd, 32'h8);
      lv(4'h8, 4'h0);
      rd_st(9'h010, 9'h1ff);
      apb(CTL, 1'b1, 32'h3);
      rd_st(9'h000, 9'h1ff);
      evt.shift_done <= 1'b1;
      rd_st(9'h010, 9'h1ff);
      evt.shift_done <= 1'b0;
      apb(CTL, 1'b1, 32'h1);
      apb(TXT, 1'b1, 32'h2);
      lv(4'h5, 4'h0);
   endtask
   // Receive level high: value plus one, saturated at depth
   task automatic t_rx();
      lv(4'h5, 4'h2);
      rd_st(9'h000, 9'h1ff);
      lv(4'h5, 4'h3);
      rd_st(9'h004, 9'h1ff);
      lv(4'h5, 4'h2);
      rd_st(9'h000, 9'h1ff);
      apb(RXT, 1'b1, 32'h0);
      lv(4'h5, 4'h1);
      rd_st(9'h004, 9'h1ff);
      apb(RXT, 1'b1, 32'hff);
      apb(RXT, 1'b0, 32'h0);
      chk(rd, 32'h8);
      lv(4'h5, 4'h7);
      rd_st(9'h000, 9'h1ff);
   endtask
   // Underflow, receive overflow, transmit overflow
   task automatic t_over();
      lv(4'h5, 4'h0);
      apb(DC, 1'b0, 32'h0);
      rd_st(9'h001, 9'h1ff);
      lv(4'h8, 4'h8);
      pulse(6'h04);
      apb(DC, 1'b0, 32'h0);
      @(negedge pclk);
      chk({rx_pop, rd[30:0]}, 32'h8000003c);
      apb(DC, 1'b1, 32'h1ff);
      @(negedge pclk);
      chk({31'h0, tx_push}, 32'h0);
      rd_st(9'h00f, 9'h1ff);
   endtask
   // Disable while the state machines are busy, then idle
   task automatic t_disable();
      evt.sm_active <= 1'b1;
      bus.frame(8'h0f);
      lv(4'h0, 4'h8);
      apb(CTL, 1'b1, 32'h0);
      rd_st(9'h01b, 9'h1ff);
      apb(i2c_ris_pkg::OFF_EN_STATUS, 1'b0, 32'h0);
      chk({fifo_flush, rd[30:0]}, 32'h80000001);
      chk({31'h0, en_stat}, 32'h1);
      evt.sm_active <= 1'b0;
      rd_st(9'h000, 9'h1ff);
      apb(i2c_ris_pkg::OFF_EN_STATUS, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, en_stat}, 32'h0);
   endtask
   // Main sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      evt = '0;
      tx_level = 4'h5;
      rx_level = 4'h0;
      rx_data = 8'h3c;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_rdreq();
      t_activity();
      t_events();
      t_tx();
      t_rx();
      t_over();
      t_disable();
      give_verdict();
   end
endmodule
